// ==== shared/pcipb_regs.svh ====
// Register offsets, field masks, field positions and reset values of the pin change block.
// Assumes a 32-bit APB slave with each register on its own aligned word.
`ifndef PCIPB_REGS_SVH
`define PCIPB_REGS_SVH

// ****************************************************************************
// Register byte offsets
// ****************************************************************************
`define PCIPB_OFS_PORTA_RISE_ENABLE 8'h00
`define PCIPB_OFS_PORTA_FALL_ENABLE 8'h04
`define PCIPB_OFS_PORTA_CHANGE_FLAGS 8'h08
`define PCIPB_OFS_PORTB_RISE_ENABLE 8'h0c
`define PCIPB_OFS_PORTB_FALL_ENABLE 8'h10
`define PCIPB_OFS_PORTB_CHANGE_FLAGS 8'h14
`define PCIPB_OFS_INTERRUPT_CONTROL 8'h18

// ****************************************************************************
// Implemented bit masks and field positions
// ****************************************************************************
`define PCIPB_PORTA_MASK 8'h3b
`define PCIPB_PORTB_MASK 8'hf0
`define PCIPB_GPBUF_PINS 8'h03
`define PCIPB_IRQ_ENABLE_BIT 3
`define PCIPB_SHARED_FLAG_BIT 0

// ****************************************************************************
// Reset values
// ****************************************************************************
`define PCIPB_RESET_BYTE 8'h00
`define PCIPB_RESET_WORD 32'h0000_0000

`endif

// ==== shared/pcipb_pkg.sv ====
// Types used by the pin change block for its pin edge events and APB requests.
// Assumes the register header is compiled alongside it.
package pcipb_pkg;

    // Edge events of one eight-pin port, one bit per pin.
    typedef struct packed {
        logic [7:0] rise;
        logic [7:0] fall;
    } pcipb_edges_type;

    // One APB request as the slave sees it.
    typedef struct packed {
        logic [7:0] addr;
        logic write;
        logic [31:0] wdata;
    } pcipb_apb_req_type;

endpackage

// ==== verilog/pcipb_pin_detect.sv ====
// Synchroniser and edge detector for one external input pin.
// Assumes the pin is asynchronous to core_clk.
`timescale 1ns/1ps

module pcipb_pin_detect (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin_async,
    output logic rise_pulse,
    output logic fall_pulse
);

    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic stable_reg;
    logic primed_reg;
    logic [2:0] fill_reg;
    logic agree;

    // A level counts only once the second and third stages agree, which rejects
    // a sample caught mid-transition.
    assign agree = (sync2_reg == sync3_reg);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= pin_async;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // Edges count only once the pin level has filled all three stages and
    // loaded the reference, so a pin that idles high gives no false rising edge.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fill_reg <= 3'h0;
            primed_reg <= 1'b0;
        end else begin
            fill_reg <= {fill_reg[1:0], 1'b1};
            primed_reg <= fill_reg[2];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stable_reg <= 1'b0;
        end else if (agree) begin
            stable_reg <= sync3_reg;
        end
    end

    // Each edge is compared with the previous agreed level.
    assign rise_pulse = primed_reg & agree & sync3_reg & ~stable_reg;
    assign fall_pulse = primed_reg & agree & ~sync3_reg & stable_reg;

endmodule // pcipb_pin_detect

// ==== verilog/pcipb_top.sv ====
// Pin change interrupt logic for port A pins 0, 1 and 3..5 and the upper four port B pins, with APB registers.
// Assumes pins are asynchronous inputs and porta_gp_buf_en comes from core_clk logic.
//
// Overview of operation
// - Port B pins 7..4 each have a falling edge enable bit.
// - An armed edge sets the pin flag and the shared change flag.
// - A cleared enable bit ignores edges of that polarity on that pin.
// - Flag sets on rising edge with rise enable or falling edge with fall enable.
// - Flags stay set until software writes zero; hardware never clears them.
// - Bits 3..0 of port B enable and flag registers read zero, ignore writes.
// - All implemented enable and flag bits reset to zero on every reset.
// - Port B pins 7..4 each have a rising edge enable bit.
// - Port A pins set their flags under the same edge rule as port B.
// - Port A pins 0 and 1 detect only while their input buffers are enabled.
//
// The address map and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "pcipb_regs.svh"

module pcipb_top (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] porta_pin_in,
    input wire logic [7:0] portb_pin_in,
    input wire logic porta_gp_buf_en,
    output logic shared_change_flag,
    output logic shared_change_irq
);
    import pcipb_pkg::*;

    // ************************************************************************
    // Pin synchronisers and edge detectors
    // ************************************************************************
    pcipb_edges_type porta_edges;
    pcipb_edges_type portb_edges;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            pcipb_pin_detect u_porta (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .pin_async(porta_pin_in[gi]),
                .rise_pulse(porta_edges.rise[gi]),
                .fall_pulse(porta_edges.fall[gi])
            );
            pcipb_pin_detect u_portb (
                .core_clk(core_clk),
                .rst_n(rst_n),
                .pin_async(portb_pin_in[gi]),
                .rise_pulse(portb_edges.rise[gi]),
                .fall_pulse(portb_edges.fall[gi])
            );
        end
    endgenerate

    // ************************************************************************
    // Registers
    // ************************************************************************
    logic [7:0] porta_rise_enable_reg;
    logic [7:0] porta_fall_enable_reg;
    logic [7:0] porta_change_flags_reg;
    logic [7:0] portb_rise_enable_reg;
    logic [7:0] portb_fall_enable_reg;
    logic [7:0] portb_change_flags_reg;
    logic shared_change_irq_enable_reg;
    logic [31:0] prdata_reg;
    logic [7:0] porta_change_flags_next;
    logic [7:0] portb_change_flags_next;

    // ************************************************************************
    // APB decode
    // ************************************************************************
    pcipb_apb_req_type req;
    logic setup_phase;
    logic wr_access;
    logic sel_a_rise;
    logic sel_a_fall;
    logic sel_a_flags;
    logic sel_b_rise;
    logic sel_b_fall;
    logic sel_b_flags;
    logic sel_interrupt_control;
    logic addr_mapped;
    logic [7:0] wbyte;
    logic [7:0] interrupt_control_view;
    logic [7:0] read_byte;

    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign wbyte = req.wdata[7:0];
    assign setup_phase = psel & ~penable;
    // The slave never inserts wait states, so every access phase completes.
    assign wr_access = psel & penable & req.write;
    assign sel_a_rise = (req.addr == `PCIPB_OFS_PORTA_RISE_ENABLE);
    assign sel_a_fall = (req.addr == `PCIPB_OFS_PORTA_FALL_ENABLE);
    assign sel_a_flags = (req.addr == `PCIPB_OFS_PORTA_CHANGE_FLAGS);
    assign sel_b_rise = (req.addr == `PCIPB_OFS_PORTB_RISE_ENABLE);
    assign sel_b_fall = (req.addr == `PCIPB_OFS_PORTB_FALL_ENABLE);
    assign sel_b_flags = (req.addr == `PCIPB_OFS_PORTB_CHANGE_FLAGS);
    assign sel_interrupt_control = (req.addr == `PCIPB_OFS_INTERRUPT_CONTROL);
    assign addr_mapped = sel_a_rise | sel_a_fall | sel_a_flags | sel_b_rise | sel_b_fall
                         | sel_b_flags | sel_interrupt_control;

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_mapped;
    assign prdata = prdata_reg;

    // ************************************************************************
    // Edge qualification
    // ************************************************************************
    logic [7:0] porta_pin_gate;
    logic [7:0] porta_hit;
    logic [7:0] portb_rise_hit;
    logic [7:0] portb_fall_hit;
    logic [7:0] portb_hit;

    // Pins 0 and 1 share the bus transceiver; with their buffers off the pins
    // read a fixed level and must not produce change events.
    assign porta_pin_gate = porta_gp_buf_en ? 8'hff : ~`PCIPB_GPBUF_PINS;
    // Rise enable with rising edge, or fall enable with falling edge.
    assign porta_hit = ((porta_edges.rise & porta_rise_enable_reg)
                        | (porta_edges.fall & porta_fall_enable_reg))
                       & porta_pin_gate & `PCIPB_PORTA_MASK;
    // A zero enable masks that polarity out entirely.
    assign portb_rise_hit = portb_edges.rise & portb_rise_enable_reg & `PCIPB_PORTB_MASK;
    assign portb_fall_hit = portb_edges.fall & portb_fall_enable_reg & `PCIPB_PORTB_MASK;
    assign portb_hit = portb_rise_hit | portb_fall_hit;

    // ************************************************************************
    // Flag update
    // ************************************************************************
    // A software write only replaces the stored bits; an edge in the same cycle
    // is ORed in afterwards so the event survives a simultaneous clear.
    assign porta_change_flags_next =
        (((wr_access & sel_a_flags) ? wbyte : porta_change_flags_reg) | porta_hit)
        & `PCIPB_PORTA_MASK;
    assign portb_change_flags_next =
        (((wr_access & sel_b_flags) ? wbyte : portb_change_flags_reg) | portb_hit)
        & `PCIPB_PORTB_MASK;

    // The shared flag is derived, never stored, so it drops exactly when the
    // last pin flag is cleared.
    assign shared_change_flag = (|porta_change_flags_reg) | (|portb_change_flags_reg);
    assign shared_change_irq = shared_change_flag & shared_change_irq_enable_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            porta_change_flags_reg <= `PCIPB_RESET_BYTE;
            portb_change_flags_reg <= `PCIPB_RESET_BYTE;
        end else begin
            porta_change_flags_reg <= porta_change_flags_next;
            portb_change_flags_reg <= portb_change_flags_next;
        end
    end

    // ************************************************************************
    // Enable registers
    // ************************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            porta_rise_enable_reg <= `PCIPB_RESET_BYTE;
            porta_fall_enable_reg <= `PCIPB_RESET_BYTE;
            portb_rise_enable_reg <= `PCIPB_RESET_BYTE;
            portb_fall_enable_reg <= `PCIPB_RESET_BYTE;
            shared_change_irq_enable_reg <= 1'b0;
        end else if (wr_access) begin
            if (sel_a_rise) begin
                porta_rise_enable_reg <= wbyte & `PCIPB_PORTA_MASK;
            end
            if (sel_a_fall) begin
                porta_fall_enable_reg <= wbyte & `PCIPB_PORTA_MASK;
            end
            if (sel_b_rise) begin
                portb_rise_enable_reg <= wbyte & `PCIPB_PORTB_MASK;
            end
            if (sel_b_fall) begin
                portb_fall_enable_reg <= wbyte & `PCIPB_PORTB_MASK;
            end
            if (sel_interrupt_control) begin
                shared_change_irq_enable_reg <= wbyte[`PCIPB_IRQ_ENABLE_BIT];
            end
        end
    end

    // ************************************************************************
    // Read path
    // ************************************************************************
    // Read data is captured in the setup phase so that it comes from a flop
    // and still needs no wait state.
    always_comb begin
        interrupt_control_view = 8'h00;
        interrupt_control_view[`PCIPB_IRQ_ENABLE_BIT] = shared_change_irq_enable_reg;
        interrupt_control_view[`PCIPB_SHARED_FLAG_BIT] = shared_change_flag;
    end

    assign read_byte = ({8{sel_a_rise}} & porta_rise_enable_reg)
                     | ({8{sel_a_fall}} & porta_fall_enable_reg)
                     | ({8{sel_a_flags}} & porta_change_flags_reg)
                     | ({8{sel_b_rise}} & portb_rise_enable_reg)
                     | ({8{sel_b_fall}} & portb_fall_enable_reg)
                     | ({8{sel_b_flags}} & portb_change_flags_reg)
                     | ({8{sel_interrupt_control}} & interrupt_control_view);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= `PCIPB_RESET_WORD;
        end else if (setup_phase) begin
            prdata_reg <= {24'h00_0000, read_byte};
        end
    end

    // ************************************************************************
    // Assertions
    // ************************************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_b_flags_write;
        psel && penable && pwrite && paddr == `PCIPB_OFS_PORTB_CHANGE_FLAGS;
    endsequence

    sequence s_b_quiet;
        portb_hit == 8'h00;
    endsequence

    chk_fall_sets_flag: assert property (
        portb_fall_hit != 8'h00 |=>
            (portb_change_flags_reg & $past(portb_fall_hit)) == $past(portb_fall_hit))
        else $error("Armed falling edge did not set its port B flag.");

    chk_rise_sets_flag: assert property (
        portb_rise_hit != 8'h00 |=>
            (portb_change_flags_reg & $past(portb_rise_hit)) == $past(portb_rise_hit))
        else $error("Armed rising edge did not set its port B flag.");

    chk_shared_follows_hit: assert property (
        (portb_hit != 8'h00 || porta_hit != 8'h00) |=> shared_change_flag ##0
            (shared_change_irq == shared_change_irq_enable_reg))
        else $error("Shared change flag not raised after an armed edge.");

    chk_flags_hold: assert property (
        (!(wr_access && sel_b_flags)) ##0 s_b_quiet |=>
            portb_change_flags_reg == $past(portb_change_flags_reg))
        else $error("Port B flags changed without an armed edge or a write.");

    chk_sw_clear: assert property (
        s_b_flags_write ##0 (pwdata[7:0] == 8'h00) ##0 s_b_quiet |=>
            portb_change_flags_reg == 8'h00
            && shared_change_flag == (porta_change_flags_reg != 8'h00))
        else $error("Writing zero did not clear the port B flags.");

    // Without a flag write, flags only rise through an armed edge, and only software lowers them.
    chk_b_flag_cause: assert property (
        !(wr_access && sel_b_flags) |=>
            (portb_change_flags_reg & ~$past(portb_change_flags_reg) & ~$past(portb_hit)) == 8'h00)
        else $error("Port B flag rose without an armed edge.");

    chk_a_flag_cause: assert property (
        !(wr_access && sel_a_flags) |=>
            (porta_change_flags_reg & ~$past(porta_change_flags_reg) & ~$past(porta_hit)) == 8'h00)
        else $error("Port A flag rose without an armed edge.");

    chk_b_no_hw_clear: assert property (
        !(wr_access && sel_b_flags) |=>
            ($past(portb_change_flags_reg) & ~portb_change_flags_reg) == 8'h00)
        else $error("Port B flag cleared without a software write.");

    chk_a_no_hw_clear: assert property (
        !(wr_access && sel_a_flags) |=>
            ($past(porta_change_flags_reg) & ~porta_change_flags_reg) == 8'h00)
        else $error("Port A flag cleared without a software write.");

    chk_unimpl_zero: assert property (
        portb_fall_enable_reg[3:0] == 4'h0 && portb_change_flags_reg[3:0] == 4'h0
        && portb_rise_enable_reg[3:0] == 4'h0)
        else $error("Unimplemented port B bits are not zero.");

    chk_porta_edge: assert property (
        porta_hit != 8'h00 |=>
            (porta_change_flags_reg & $past(porta_hit)) == $past(porta_hit))
        else $error("Armed port A edge did not set its flag.");

    chk_gpbuf_gate: assert property (
        !porta_gp_buf_en && !(wr_access && sel_a_flags) |=>
            porta_change_flags_reg[1:0] == $past(porta_change_flags_reg[1:0]))
        else $error("Port A pin 0 or 1 flagged while its input buffer is off.");

    chk_reset_clear: assert property (@(posedge core_clk)
        $rose(rst_n) |-> porta_change_flags_reg == 8'h00 && portb_change_flags_reg == 8'h00
            && portb_fall_enable_reg == 8'h00 && portb_rise_enable_reg == 8'h00)
        else $error("Registers not zero after reset release.");

    chk_shared_or: assert property (
        ##1 shared_change_flag == ($past(porta_change_flags_next) != 8'h00
            || $past(portb_change_flags_next) != 8'h00))
        else $error("Shared flag differs from the OR of the pin flags.");

endmodule // pcipb_top

// ==== bench/pcipb_pin_model.sv ====
// Model of the external sources that drive the port A and port B input pins.
// Assumes the bench sets the wanted levels at rising edges of core_clk.
`timescale 1ns/1ps

module pcipb_pin_model (
    input wire logic core_clk,
    input wire logic [7:0] pa_want,
    input wire logic [7:0] pb_want,
    output logic [7:0] porta_pin,
    output logic [7:0] portb_pin
);
    // ************************************************************************
    // Pin drivers
    // ************************************************************************
    // Real sources are unrelated to core_clk, so levels move 3 ns after the edge
    // that follows the request. The pins are defined from the first edge, long
    // before reset ends, so the synchronisers never take in an unknown level.
    always @(posedge core_clk) begin
        porta_pin <= #3 pa_want;
        portb_pin <= #3 pb_want;
    end
endmodule // pcipb_pin_model

// ==== bench/pcipb_tb_top.sv ====
// Self-checking bench of the pin change block: APB register tasks and pin edge tests.
// Assumes the design answers APB with pready and sets flags a few edges after a pin edge.
`timescale 1ns/1ps
`include "pcipb_regs.svh"

module pcipb_tb_top;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] porta_pin;
    logic [7:0] portb_pin;
    logic [7:0] pa_want = 8'h00;
    logic [7:0] pb_want = 8'h00;
    logic porta_gp_buf_en = 1'b1;
    logic shared_change_flag;
    logic shared_change_irq;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;

    always #5 core_clk = ~core_clk;

    pcipb_top i_pcipb_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .porta_pin_in(porta_pin),
        .portb_pin_in(portb_pin), .porta_gp_buf_en(porta_gp_buf_en),
        .shared_change_flag(shared_change_flag), .shared_change_irq(shared_change_irq));

    pcipb_pin_model i_pcipb_pin_model (.core_clk(core_clk), .pa_want(pa_want),
        .pb_want(pb_want), .porta_pin(porta_pin), .portb_pin(portb_pin));

    // ************************************************************************
    // Checking and closing
    // ************************************************************************
    task automatic chk(input logic [31:0] act, input logic [31:0] exp);
        num_checks++;
        if (act !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("Checks made: %0d, mismatches: %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // The whole run takes well under 3000 cycles, so 20000 means a hang.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // ************************************************************************
    // APB master
    // ************************************************************************
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(a, 1'b1, {24'h0, d}, r, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        apb(a, 1'b0, 32'h0, r, e);
        chk(r, {24'h0, exp});
        chk({31'h0, e}, 32'h0);
    endtask

    task automatic outs(input logic f, input logic ien);
        chk({30'h0, shared_change_flag, shared_change_irq}, {30'h0, f, f & ien});
    endtask

    // Flags land five edges after the bench asks for a level; six leaves margin.
    task automatic settle();
        repeat (6) @(posedge core_clk);
    endtask

    // ************************************************************************
    // Tests
    // ************************************************************************
    logic [7:0] ofs [7] = '{`PCIPB_OFS_PORTA_RISE_ENABLE, `PCIPB_OFS_PORTA_FALL_ENABLE,
        `PCIPB_OFS_PORTA_CHANGE_FLAGS, `PCIPB_OFS_PORTB_RISE_ENABLE,
        `PCIPB_OFS_PORTB_FALL_ENABLE, `PCIPB_OFS_PORTB_CHANGE_FLAGS,
        `PCIPB_OFS_INTERRUPT_CONTROL};
    logic [7:0] msk [7] = '{8'h3b, 8'h3b, 8'h3b, 8'hf0, 8'hf0, 8'hf0, 8'h09};
    int pa_pins [5] = '{0, 1, 3, 4, 5};
    logic [31:0] r;
    logic e;
    logic [7:0] b;
    logic [7:0] x;

    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < 7; i++) rd(ofs[i], 8'h00);
        outs(1'b0, 1'b0);
        // All ones lands only on implemented bits; flag writes of one set flags.
        for (int i = 0; i < 7; i++) wr(ofs[i], 8'hff);
        for (int i = 0; i < 7; i++) rd(ofs[i], msk[i]);
        outs(1'b1, 1'b1);
        wr(`PCIPB_OFS_PORTA_CHANGE_FLAGS, 8'h00);
        wr(`PCIPB_OFS_PORTB_CHANGE_FLAGS, 8'h00);
        rd(`PCIPB_OFS_INTERRUPT_CONTROL, 8'h08);
        outs(1'b0, 1'b1);
        apb(8'h1c, 1'b1, 32'hffff_ffff, r, e);
        chk({31'h0, e}, 32'h1);
        apb(8'h1c, 1'b0, 32'h0, r, e);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        // Port B: every enable combination on pins 4 to 7, both edge polarities.
        for (int p = 4; p < 8; p++) begin
            for (int m = 0; m < 4; m++) begin
                b = 8'h01 << p;
                wr(`PCIPB_OFS_PORTB_RISE_ENABLE, m[0] ? b : 8'h00);
                wr(`PCIPB_OFS_PORTB_FALL_ENABLE, m[1] ? b : 8'h00);
                pb_want <= pb_want | b;
                settle();
                x = m[0] ? b : 8'h00;
                rd(`PCIPB_OFS_PORTB_CHANGE_FLAGS, x);
                outs(x != 8'h00, 1'b1);
                pb_want <= pb_want & ~b;
                settle();
                x = x | (m[1] ? b : 8'h00);
                rd(`PCIPB_OFS_PORTB_CHANGE_FLAGS, x);
                outs(x != 8'h00, 1'b1);
                wr(`PCIPB_OFS_PORTB_CHANGE_FLAGS, 8'h00);
                rd(`PCIPB_OFS_PORTB_CHANGE_FLAGS, 8'h00);
            end
        end
        // Port A with the interrupt enable off; pins 0 and 1 need the input buffer.
        wr(`PCIPB_OFS_INTERRUPT_CONTROL, 8'h00);
        wr(`PCIPB_OFS_PORTB_RISE_ENABLE, 8'h00);
        wr(`PCIPB_OFS_PORTB_FALL_ENABLE, 8'h00);
        wr(`PCIPB_OFS_PORTA_RISE_ENABLE, 8'h3b);
        wr(`PCIPB_OFS_PORTA_FALL_ENABLE, 8'h3b);
        for (int g = 0; g < 2; g++) begin
            porta_gp_buf_en <= g[0];
            for (int i = 0; i < 5; i++) begin
                b = 8'h01 << pa_pins[i];
                x = (pa_pins[i] < 2 && g == 0) ? 8'h00 : b;
                pa_want <= pa_want | b;
                settle();
                rd(`PCIPB_OFS_PORTA_CHANGE_FLAGS, x);
                outs(x != 8'h00, 1'b0);
                wr(`PCIPB_OFS_PORTA_CHANGE_FLAGS, 8'h00);
                pa_want <= pa_want & ~b;
                settle();
                rd(`PCIPB_OFS_PORTA_CHANGE_FLAGS, x);
                wr(`PCIPB_OFS_PORTA_CHANGE_FLAGS, 8'h00);
                rd(`PCIPB_OFS_PORTA_CHANGE_FLAGS, 8'h00);
            end
        end
        // A reset in mid-run must clear whatever software left behind.
        for (int i = 0; i < 7; i++) wr(ofs[i], 8'hff);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        for (int i = 0; i < 7; i++) rd(ofs[i], 8'h00);
        outs(1'b0, 1'b0);
        tally_and_finish();
    end
endmodule // pcipb_tb_top
